// ---- design/device_name_set_command.sv ----
// Name-setting command interpreter on the host byte stream
module device_name_set_command #(
  parameter logic [7:0] ERROR_BYTE = name_cmd_pkg::ERROR_REPLY
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic adv_on,
  input wire logic central_connected,
  input wire logic [name_cmd_pkg::ADDR_BITS-1:0] dev_addr,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output name_cmd_pkg::name_rec_t name_rec,
  output logic name_updated,
  output logic cmd_rejected
);

  name_cmd_pkg::parse_state_t state_reg; // Packet walk position
  name_cmd_pkg::parse_state_t state_next;
  logic [7:0] opt_reg; // Option byte of the packet in flight
  logic [7:0] opt_next;
  logic [name_cmd_pkg::NAME_FIELD_LEN-1:0][7:0] field_reg; // Raw name field
  logic [name_cmd_pkg::NAME_FIELD_LEN-1:0][7:0] field_next;
  logic [3:0] idx_reg; // Name byte position
  logic [3:0] idx_next;
  logic [4:0] len_reg; // Meaningful characters so far
  logic [4:0] len_next;
  logic null_seen_reg; // Terminator already met
  logic null_seen_next;
  logic busy_seen_reg; // Radio was busy at some point of the packet
  logic busy_seen_next;
  logic [7:0] reply_reg; // Answer byte waiting for the buffer
  logic [7:0] reply_next;
  name_cmd_pkg::name_rec_t rec_reg; // Committed name and options
  name_cmd_pkg::name_rec_t rec_next;
  logic upd_reg; // One-cycle commit strobe
  logic upd_next;
  logic rej_reg; // One-cycle refusal strobe
  logic rej_next;

  logic take; // A byte is taken this cycle
  logic busy; // Advertising or connected
  logic buf_in_valid;
  logic buf_in_ready;
  logic [name_cmd_pkg::SUFFIX_CHARS-1:0][7:0] suffix_chars;
  name_cmd_pkg::name_rec_t built_rec; // Name as it would be committed

  assign busy = adv_on || central_connected;
  assign take = rx_valid && rx_ready;
  assign name_rec = rec_reg;
  assign name_updated = upd_reg;
  assign cmd_rejected = rej_reg;

  // Nibble to upper-case hex character
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    logic [7:0] res;
    res = 8'h00;
    if (nib < 4'ha) begin
      res = 8'h30 + {4'h0, nib};
    end else begin
      res = 8'h37 + {4'h0, nib};
    end
    return res;
  endfunction

  // Low address bytes as text, most significant digit first
  always_comb begin
    suffix_chars = '0;
    for (int k = 0; k < name_cmd_pkg::SUFFIX_CHARS; k++) begin
      suffix_chars[k] = hex_char(dev_addr[23 - 4 * k -: 4]);
    end
  end

  // Assemble the record that a good end marker would commit
  always_comb begin
    built_rec = '0;
    built_rec.bond_enable = opt_reg[name_cmd_pkg::OPT_BOND_BIT];
    built_rec.suffix_enable = opt_reg[name_cmd_pkg::OPT_SUFFIX_BIT];
    built_rec.length = len_reg;
    for (int i = 0; i < name_cmd_pkg::STORE_LEN; i++) begin
      built_rec.chars[i] = name_cmd_pkg::RESET_CHAR;
      if (i < 32'(len_reg)) begin
        // Only characters before the terminator survive
        built_rec.chars[i] = field_reg[i];
      end else if (built_rec.suffix_enable &&
                   (i - 32'(len_reg)) < name_cmd_pkg::SUFFIX_CHARS) begin
        // Suffix follows the last name character directly
        built_rec.chars[i] = suffix_chars[i - 32'(len_reg)];
      end
    end
    if (built_rec.suffix_enable) begin
      built_rec.length = len_reg + 5'(name_cmd_pkg::SUFFIX_CHARS);
    end
  end

  // Packet walk, one byte per state step
  always_comb begin
    state_next = state_reg;
    opt_next = opt_reg;
    field_next = field_reg;
    idx_next = idx_reg;
    len_next = len_reg;
    null_seen_next = null_seen_reg;
    busy_seen_next = busy_seen_reg || busy;
    reply_next = reply_reg;
    rec_next = rec_reg;
    upd_next = 1'b0;
    rej_next = 1'b0;
    // Input stalls while an answer waits, so the buffer back-pressures parsing
    rx_ready = (state_reg != name_cmd_pkg::ST_REPLY);
    buf_in_valid = 1'b0;
    case (state_reg)
      name_cmd_pkg::ST_START: begin
        // Hunt for the start marker; stray bytes are dropped
        if (take && rx_data == name_cmd_pkg::PACKET_START_MARKER) begin
          state_next = name_cmd_pkg::ST_CODE;
        end
      end
      name_cmd_pkg::ST_CODE: begin
        if (take) begin
          if (rx_data == name_cmd_pkg::CMD_SET_NAME) begin
            state_next = name_cmd_pkg::ST_OPTION;
            // Busy tracking starts fresh with this packet
            busy_seen_next = busy;
          end else begin
            // Other commands belong to other handlers
            state_next = name_cmd_pkg::ST_START;
          end
        end
      end
      name_cmd_pkg::ST_OPTION: begin
        if (take) begin
          // Reserved bits are kept but never acted upon
          opt_next = rx_data;
          idx_next = 4'h0;
          len_next = name_cmd_pkg::RESET_LEN;
          null_seen_next = 1'b0;
          state_next = name_cmd_pkg::ST_NAME;
        end
      end
      name_cmd_pkg::ST_NAME: begin
        if (take) begin
          field_next[idx_reg] = rx_data;
          if (!null_seen_reg && rx_data == 8'h00) begin
            null_seen_next = 1'b1;
          end else if (!null_seen_reg &&
                       len_reg < 5'(name_cmd_pkg::NAME_MAX_CHARS)) begin
            // Cap at fourteen: a full field without null loses its last byte
            len_next = len_reg + 5'h01;
          end
          // All fifteen bytes are always consumed, filler included
          if (idx_reg == 4'(name_cmd_pkg::NAME_FIELD_LEN - 1)) begin
            state_next = name_cmd_pkg::ST_END;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end
      end
      name_cmd_pkg::ST_END: begin
        if (take) begin
          state_next = name_cmd_pkg::ST_REPLY;
          if (rx_data == name_cmd_pkg::PACKET_END_MARKER &&
              !busy_seen_reg && !busy) begin
            rec_next = built_rec;
            upd_next = 1'b1;
            reply_next = name_cmd_pkg::PACKET_END_MARKER;
          end else begin
            // Stored name and options stay as they were
            rej_next = 1'b1;
            reply_next = ERROR_BYTE;
          end
        end
      end
      name_cmd_pkg::ST_REPLY: begin
        buf_in_valid = 1'b1;
        if (buf_in_ready) begin
          state_next = name_cmd_pkg::ST_START;
        end
      end
      default: begin
        state_next = name_cmd_pkg::ST_START;
      end
    endcase
  end

  // Register stage for the walk and the committed settings
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= name_cmd_pkg::ST_START;
      opt_reg <= 8'h00;
      field_reg <= '0;
      idx_reg <= 4'h0;
      len_reg <= name_cmd_pkg::RESET_LEN;
      null_seen_reg <= 1'b0;
      busy_seen_reg <= 1'b0;
      reply_reg <= 8'h00;
      rec_reg <= '0;
      upd_reg <= name_cmd_pkg::RESET_FLAG;
      rej_reg <= name_cmd_pkg::RESET_FLAG;
    end else begin
      state_reg <= state_next;
      opt_reg <= opt_next;
      field_reg <= field_next;
      idx_reg <= idx_next;
      len_reg <= len_next;
      null_seen_reg <= null_seen_next;
      busy_seen_reg <= busy_seen_next;
      reply_reg <= reply_next;
      rec_reg <= rec_next;
      upd_reg <= upd_next;
      rej_reg <= rej_next;
    end
  end

  // Answer bytes leave through the two-entry buffer
  reply_buffer #(
    .WIDTH(8)
  ) u_reply_buffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(buf_in_valid),
    .in_data(reply_reg),
    .in_ready(buf_in_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

endmodule

// ---- design/name_cmd_pkg.sv ----
// Overview of operation
// - Parse start, code, option, fifteen name bytes, end.
// - Accept only when not advertising, not connected.
// - Stored name holds up to fourteen characters.
// - Option bit 0 enables address suffix.
// - Option bit 1 enables bonding; others reserved.
// - Name field fixed fifteen bytes, null terminated.
// - Suffix is three low address bytes as ASCII.
package name_cmd_pkg;

  // Framing bytes of the command link
  localparam logic [7:0] PACKET_START_MARKER = 8'ha5;
  localparam logic [7:0] CMD_SET_NAME = 8'h0b;
  localparam logic [7:0] PACKET_END_MARKER = 8'ha6;
  // Error answer byte
  localparam logic [7:0] ERROR_REPLY = 8'hee;

  // Field layout of the option byte
  localparam int OPT_SUFFIX_BIT = 0;
  localparam int OPT_BOND_BIT = 1;

  // Sizes of the name field and the stored name
  localparam int NAME_FIELD_LEN = 15;
  localparam int NAME_MAX_CHARS = 14;
  localparam int SUFFIX_BYTES = 3;
  localparam int SUFFIX_CHARS = 2 * SUFFIX_BYTES;
  // One spare byte keeps a null after the longest name plus suffix
  localparam int STORE_LEN = NAME_MAX_CHARS + SUFFIX_CHARS + 1;
  localparam int ADDR_BITS = 48;

  // Reset values of the stored settings
  localparam logic [7:0] RESET_CHAR = 8'h00;
  localparam logic [4:0] RESET_LEN = 5'h00;
  localparam logic RESET_FLAG = 1'b0;

  // Committed name and options as seen by the rest of the module
  typedef struct packed {
    logic bond_enable;
    logic suffix_enable;
    logic [4:0] length;
    logic [STORE_LEN-1:0][7:0] chars;
  } name_rec_t;

  // Packet walk states
  typedef enum {
    ST_START,
    ST_CODE,
    ST_OPTION,
    ST_NAME,
    ST_END,
    ST_REPLY
  } parse_state_t;

endpackage

// ---- design/reply_buffer.sv ----
// Two-entry buffer: a stall by the receiver loses no word
module reply_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic [1:0][WIDTH-1:0] slot_reg; // Storage slots
  logic [1:0][WIDTH-1:0] slot_next;
  logic wr_ptr_reg; // Slot written next
  logic wr_ptr_next;
  logic rd_ptr_reg; // Slot read next
  logic rd_ptr_next;
  logic [1:0] count_reg; // Entries held, 0 to 2
  logic [1:0] count_next;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  // Read data comes from a register slot
  assign out_data = slot_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointers, count and slot contents
  always_comb begin
    slot_next = slot_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      slot_next[wr_ptr_reg] = in_data;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    // Push and pop together leave the count unchanged
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slot_reg <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      slot_reg <= slot_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule

// ---- tb/name_cmd_asserts.sv ----
// Watches the name command block from its ports only
module name_cmd_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic rx_ready,
  input wire logic adv_on,
  input wire logic central_connected,
  input wire logic [name_cmd_pkg::ADDR_BITS-1:0] dev_addr,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire name_cmd_pkg::name_rec_t name_rec,
  input wire logic name_updated,
  input wire logic cmd_rejected
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Upper-case hex digit, as the suffix is written
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  property p_pulse; name_updated |=> !name_updated; endproperty
  a_pulse: assert property (p_pulse) else $error("commit pulse too long");
  property p_excl; !(name_updated && cmd_rejected); endproperty
  a_excl: assert property (p_excl) else $error("commit and refusal together");
  property p_keep; !$stable(name_rec) |-> name_updated; endproperty
  a_keep: assert property (p_keep) else $error("name changed without commit");
  property p_rej; cmd_rejected |-> $stable(name_rec); endproperty
  a_rej: assert property (p_rej) else $error("refused packet changed name");
  property p_idle; name_updated |-> !$past(adv_on) && !$past(central_connected); endproperty
  a_idle: assert property (p_idle) else $error("commit while busy");
  property p_stall; name_updated |-> !rx_ready; endproperty
  a_stall: assert property (p_stall) else $error("input open during reply");
  property p_len;
    name_updated |-> name_rec.length <= (name_rec.suffix_enable ? 5'd20 : 5'd14);
  endproperty
  a_len: assert property (p_len) else $error("stored name too long");
  property p_null; name_updated |-> name_rec.chars[name_rec.length] == 8'h00; endproperty
  a_null: assert property (p_null) else $error("no terminator after name");
  property p_sfx;
    name_updated && name_rec.suffix_enable |->
      name_rec.chars[name_rec.length - 5'd1] == hexc(dev_addr[3:0]) &&
      name_rec.chars[name_rec.length - 5'd6] == hexc(dev_addr[23:20]);
  endproperty
  a_sfx: assert property (p_sfx) else $error("address suffix wrong");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("answer dropped while stalled");
  // Main scenarios
  c_sfx: cover property (name_updated && name_rec.suffix_enable);
  c_rej: cover property (cmd_rejected);
  c_full: cover property (tx_valid && !tx_ready && !rx_ready);
endmodule
bind device_name_set_command name_cmd_asserts name_cmd_asserts_inst (.clk_sys(clk_sys),
  .reset(reset), .rx_ready(rx_ready), .adv_on(adv_on), .central_connected(central_connected),
  .dev_addr(dev_addr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .name_rec(name_rec), .name_updated(name_updated), .cmd_rejected(cmd_rejected));

// ---- tb/host_model.sv ----
// Host side: sends queued bytes, collects answers, stalls on demand
module host_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stall,
  input wire logic hold,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$]; // Bytes still to send, packets and stray bytes in order
  logic [7:0] rq[$]; // Answers received
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // A byte stands until taken; an idle line flips so no stale value passes
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) rq.push_back(tx_data);
    if (!rx_valid || rx_ready) begin
      if (!reset && !stall && q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data <= q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
    // Hold refuses answers only; bytes keep flowing toward the parser
    tx_ready <= !stall && !hold;
  end
endmodule

// ---- tb/tb.sv ----
// Packet-level bench with a queue model of the expected answers and name
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset, adv_on, central_connected, stall, hold;
  logic [name_cmd_pkg::ADDR_BITS-1:0] dev_addr;
  logic rx_valid, rx_ready, tx_valid, tx_ready, name_updated, cmd_rejected;
  logic [7:0] rx_data, tx_data;
  logic [7:0] exp_q[$]; // Answers expected, in order
  name_cmd_pkg::name_rec_t name_rec, exp_rec;
  int error_cnt = 0, tests_run = 0, seed = 74881, upd_cnt = 0, exp_upd = 0;
  int rej_cnt = 0, exp_rej = 0; // Refusal pulses seen and expected
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  device_name_set_command device_name_set_command_inst (.clk_sys(clk_sys), .reset(reset),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .adv_on(adv_on),
    .central_connected(central_connected), .dev_addr(dev_addr), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .name_rec(name_rec),
    .name_updated(name_updated), .cmd_rejected(cmd_rejected));
  host_model host_model_inst (.clk_sys(clk_sys), .reset(reset), .stall(stall), .hold(hold),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready));
  // Random gaps on both sides; hold blocks only the answers, so the parser fills the buffer
  always @(posedge clk_sys) begin
    stall <= ({$random(seed)} % 4 == 0);
    upd_cnt <= upd_cnt + int'(name_updated);
    rej_cnt <= rej_cnt + int'(cmd_rejected);
  end
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic check(string what, logic [191:0] seen, logic [191:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Queue one packet with a random name; null at a random place or none
  task automatic send(logic [7:0] code, logic [7:0] name_option_byte, logic [7:0] eop);
    logic [7:0] nm[15];
    int z, n;
    z = {$random(seed)} % 16;
    for (int i = 0; i < 15; i++) nm[i] = (i == z) ? 8'h00 : 8'h21 + 8'({$random(seed)} % 90);
    host_model_inst.q.push_back(name_cmd_pkg::PACKET_START_MARKER);
    host_model_inst.q.push_back(code);
    host_model_inst.q.push_back(name_option_byte);
    for (int i = 0; i < 15; i++) host_model_inst.q.push_back(nm[i]);
    host_model_inst.q.push_back(eop);
    if (code == name_cmd_pkg::CMD_SET_NAME && eop == name_cmd_pkg::PACKET_END_MARKER &&
        !adv_on && !central_connected) begin
      exp_q.push_back(name_cmd_pkg::PACKET_END_MARKER);
      exp_upd++;
      exp_rec = '0;
      exp_rec.bond_enable = name_option_byte[1];
      exp_rec.suffix_enable = name_option_byte[0];
      n = 0;
      while (n < 14 && nm[n] != 8'h00) begin
        exp_rec.chars[n] = nm[n];
        n++;
      end
      for (int i = 0; i < 6; i++) if (name_option_byte[0]) exp_rec.chars[n + i] = hexc(dev_addr[23 - 4 * i -: 4]);
      exp_rec.length = 5'(name_option_byte[0] ? n + 6 : n);
    end else if (code == name_cmd_pkg::CMD_SET_NAME) begin
      exp_rej++;
      exp_q.push_back(name_cmd_pkg::ERROR_REPLY);
    end
  endtask
  // Wait for every expected answer, then compare answers and stored name
  task automatic drain(string name);
    int k;
    k = 0;
    while (host_model_inst.rq.size() < exp_q.size() && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    while (exp_q.size() > 0 && host_model_inst.rq.size() > 0) begin
      check("answer", 192'(host_model_inst.rq.pop_front()), 192'(exp_q.pop_front()));
    end
    check("missing", 192'(exp_q.size() + host_model_inst.rq.size()), 192'(0));
    check("name", 192'(name_rec), 192'(exp_rec));
    check("commits", 192'(upd_cnt), 192'(exp_upd));
    check("refusals", 192'(rej_cnt), 192'(exp_rej));
    $display("Test %s done", name);
  endtask
  initial begin
    reset = 1'b1;
    hold = 1'b0;
    adv_on = 1'b0;
    central_connected = 1'b0;
    dev_addr = '0;
    exp_rec = '0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    // Every suffix and bond setting, reserved bits random
    for (int t = 0; t < 12; t++) begin
      dev_addr <= 48'({$random(seed), $random(seed)});
      @(posedge clk_sys);
      send(name_cmd_pkg::CMD_SET_NAME, {6'($random(seed)), 2'(t)}, 8'ha6);
      drain("options");
    end
    // Refusals while busy, bad end byte, foreign code, stray bytes
    adv_on <= 1'b1;
    @(posedge clk_sys);
    send(name_cmd_pkg::CMD_SET_NAME, 8'h03, 8'ha6);
    drain("advertising");
    adv_on <= 1'b0;
    central_connected <= 1'b1;
    @(posedge clk_sys);
    send(name_cmd_pkg::CMD_SET_NAME, 8'h01, 8'ha6);
    drain("connected");
    central_connected <= 1'b0;
    // Let the idle level settle before the model reads it
    @(posedge clk_sys);
    send(name_cmd_pkg::CMD_SET_NAME, 8'h01, 8'h55);
    host_model_inst.q.push_back(8'h00);
    host_model_inst.q.push_back(8'ha5);
    host_model_inst.q.push_back(8'h0c);
    send(name_cmd_pkg::CMD_SET_NAME, 8'h02, 8'ha6);
    drain("framing");
    // Receiver stalls: two answers buffered, third packet holds the parser
    hold <= 1'b1;
    for (int t = 0; t < 4; t++) send(name_cmd_pkg::CMD_SET_NAME, 8'(t), 8'ha6);
    repeat (150) @(posedge clk_sys);
    check("stalled", 192'(rx_ready), 192'(0));
    hold <= 1'b0;
    drain("buffer");
    stop_test();
  end
  // Cut a hang short well beyond the expected run time
  initial begin
    #(40 * 20000);
    error_cnt++;
    stop_test();
  end
endmodule
